// ===== hw/lpt_pkg.sv
package lpt_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] CONTROL_STATUS_OFS = 12'h000;
  localparam logic [11:0] DIVIDER_CONFIG_OFS = 12'h004;
  localparam logic [11:0] COMPARE_VALUE_OFS = 12'h008;
  localparam logic [11:0] COUNT_VALUE_OFS = 12'h00C;

  // ---------------------------------------------------------------
  // Control/status fields
  // ---------------------------------------------------------------
  localparam int CS_ENABLE = 0;
  localparam int CS_PULSE_MODE = 1;
  localparam int CS_FREE_RUN = 2;
  localparam int CS_ACTIVE_LOW = 3;
  localparam int CS_INPUT_SEL_LO = 4;
  localparam int CS_IRQ_ENABLE = 6;
  localparam int CS_FLAG = 7;

  // ---------------------------------------------------------------
  // Divider config fields
  // ---------------------------------------------------------------
  localparam int DC_SOURCE_LO = 0;
  localparam int DC_BYPASS = 2;
  localparam int DC_DIVIDE_LO = 3;

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int COUNT_WIDTH = 16;
  localparam int NUM_SOURCES = 4;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [3:0] DIVIDE_RESET = 4'h0;
  localparam logic [1:0] SOURCE_RESET = 2'h0;
endpackage

// ===== hw/lpt_timer.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
// Summary of operation
// - Source select codes 00..11 route clock input 0..3 to prescaler/filter.
// - Compare and count are 16 bits; bits 31..16 read zero.
// - Count equal to compare then incrementing sets flag and trigger.
// - Compare zero without free running keeps trigger high until disabled.
// - Compare event sets flag, interrupts if enabled, triggers, clears count unless free.
// - Nonzero compare or free running drops trigger at next increment.
// - Only power-on or low-voltage reset resets the timer.
// - Time mode with prescaler counts once per 2^1..2^16 source edges.
// - Bypassed time mode counts every source edge; the first edge after enable counts with no added delay.
// - Filter output starts asserted when the timer is first enabled.
// - Filter output changes after 2^n consecutive edges at new level.
// - Filtered pulse mode counts each filter assertion, rate limited.
// - Bypassed pulse mode counts input assertions; input forced asserted before enable.
// - Count clears when disabled and wraps to zero on overflow.
// - Debug halt stops time mode counting but not pulse mode.
// - Writing count register snapshots live count; reads return snapshot.
// - Interrupt is flag and enable; flag clears on disable or write one.
// - Interrupt output is combinational, needing no clock to reach wakeup logic.
// - Divide setting n gives division 2^(n+1) and filter width 2^n.
// - Bypass set clocks counter from source edges (time) or input assertions (pulse) directly, else from prescaler/filter.
module lpt_timer
  import lpt_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_SOURCES-1:0] clock_source,
  input wire logic [NUM_SOURCES-1:0] pulse_pin,
  input wire logic debug_halt,
  output logic compare_irq,
  output logic hw_trigger
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic timer_enable, pulse_mode, free_running_count, active_low;
  logic [1:0] input_select;
  logic compare_irq_enable, compare_flag;
  logic [1:0] clock_source_select;
  logic filter_bypass;
  logic [3:0] divide_setting;
  logic [COUNT_WIDTH-1:0] compare_value, count, count_snapshot;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic setup_phase;
  logic wr_access, wr_control, wr_count;
  logic mapped;

  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign wr_control = wr_access && (paddr == CONTROL_STATUS_OFS);
  assign wr_count = wr_access && (paddr == COUNT_VALUE_OFS);
  assign mapped = (paddr == CONTROL_STATUS_OFS) || (paddr == DIVIDER_CONFIG_OFS) ||
                  (paddr == COMPARE_VALUE_OFS) || (paddr == COUNT_VALUE_OFS);
  // Every access completes with no wait states.
  assign pready = 1'b1;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [NUM_SOURCES-1:0] src_meta, src_sync;
  logic [NUM_SOURCES-1:0] pin_meta, pin_sync;

  // Each source and pin passes two flops before any logic reads it.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SOURCES; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        if (reset) begin
          src_meta[gi] <= 1'b0;
          src_sync[gi] <= 1'b0;
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          src_meta[gi] <= clock_source[gi];
          src_sync[gi] <= src_meta[gi];
          pin_meta[gi] <= pulse_pin[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Source selection and edge detection
  // ---------------------------------------------------------------
  logic src_level, src_prev, src_edge, input_active;

  assign src_level = src_sync[clock_source_select];
  assign src_edge = src_level && !src_prev;
  // Polarity folded in so all pulse logic sees an active-high input.
  assign input_active = pin_sync[input_select] ^ active_low;

  // The previous sample tracks the source even while disabled, so it adds no enable latency after sync.
  always_ff @(posedge clock) begin
    if (reset) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_level;
    end
  end

  // ---------------------------------------------------------------
  // Prescaler and glitch filter share one counter
  // ---------------------------------------------------------------
  logic [15:0] div_count, div_terminal, filter_width;
  logic filter_out, input_prev;
  logic divide_setting_tick, filter_tick, bypass_pulse_tick;

  // Division 2^(n+1) ends at 2^(n+1)-1; the filter needs 2^n samples.
  // A five-bit shift amount keeps setting 15 from wrapping to a shift of zero.
  assign div_terminal = 16'((17'h0_0001 << (5'(divide_setting) + 5'h01)) - 17'h0_0001);
  assign filter_width = 16'(17'h0_0001 << divide_setting);
  assign divide_setting_tick = src_edge && (div_count == div_terminal);
  assign filter_tick = src_edge && !filter_out && input_active &&
                       (div_count == 16'(filter_width - 16'h0001));
  assign bypass_pulse_tick = input_active && !input_prev;

  // In time mode the counter divides source edges; in pulse mode it counts
  // consecutive edges where the input differs from the filter output.
  always_ff @(posedge clock) begin
    if (reset || !timer_enable) begin
      div_count <= 16'h0000;
    end else if (src_edge) begin
      if (!pulse_mode) begin
        div_count <= divide_setting_tick ? 16'h0000 : div_count + 16'h0001;
      end else if (input_active == filter_out) begin
        div_count <= 16'h0000;
      end else if (div_count == 16'(filter_width - 16'h0001)) begin
        div_count <= 16'h0000;
      end else begin
        div_count <= div_count + 16'h0001;
      end
    end
  end

  // Filter output is held asserted while disabled, so a pin already active
  // at enable is not counted.
  always_ff @(posedge clock) begin
    if (reset || !timer_enable) begin
      filter_out <= 1'b1;
    end else if (src_edge && pulse_mode && input_active != filter_out &&
                 div_count == 16'(filter_width - 16'h0001)) begin
      filter_out <= input_active;
    end
  end

  // Raw input history, forced asserted before enable.
  always_ff @(posedge clock) begin
    if (reset || !timer_enable) begin
      input_prev <= 1'b1;
    end else begin
      input_prev <= input_active;
    end
  end

  // ---------------------------------------------------------------
  // Increment selection
  // ---------------------------------------------------------------
  logic count_tick, match, compare_event;

  // Time mode freezes under debug halt; pulse mode keeps running.
  always_comb begin
    count_tick = 1'b0;
    if (timer_enable) begin
      if (!pulse_mode) begin
        count_tick = !debug_halt && (filter_bypass ? src_edge : divide_setting_tick);
      end else begin
        count_tick = filter_bypass ? bypass_pulse_tick : filter_tick;
      end
    end
  end

  assign match = (count == compare_value);
  assign compare_event = count_tick && match;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  // Overflow wraps naturally through the 16-bit add.
  always_ff @(posedge clock) begin
    if (reset || !timer_enable) begin
      count <= COUNT_RESET;
    end else if (compare_event && !free_running_count) begin
      count <= COUNT_RESET;
    end else if (count_tick) begin
      count <= count + 16'h0001;
    end
  end

  // Snapshot for software; a read before any write returns the reset value, zero.
  always_ff @(posedge clock) begin
    if (reset) begin
      count_snapshot <= COUNT_RESET;
    end else if (wr_count) begin
      count_snapshot <= count;
    end
  end

  // ---------------------------------------------------------------
  // Compare flag and hardware trigger
  // ---------------------------------------------------------------
  // Setting wins over a write-one clear in the same cycle.
  always_ff @(posedge clock) begin
    if (reset || !timer_enable) begin
      compare_flag <= 1'b0;
    end else if (compare_event) begin
      compare_flag <= 1'b1;
    end else if (wr_control && pwdata[CS_FLAG]) begin
      compare_flag <= 1'b0;
    end
  end

  // A zero compare without free running latches the trigger until the timer is disabled.
  always_ff @(posedge clock) begin
    if (reset || !timer_enable) begin
      hw_trigger <= 1'b0;
    end else if (compare_event) begin
      hw_trigger <= 1'b1;
    end else if (count_tick && (compare_value != 16'h0000 || free_running_count)) begin
      hw_trigger <= 1'b0;
    end
  end

  // Kept combinational so it reaches wakeup logic with no clock running.
  assign compare_irq = compare_flag && compare_irq_enable;

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // The enable bit and interrupt enable may change at any time.
  always_ff @(posedge clock) begin
    if (reset) begin
      timer_enable <= 1'b0;
      pulse_mode <= 1'b0;
      free_running_count <= 1'b0;
      active_low <= 1'b0;
      input_select <= 2'h0;
      compare_irq_enable <= 1'b0;
    end else if (wr_control) begin
      timer_enable <= pwdata[CS_ENABLE];
      pulse_mode <= pwdata[CS_PULSE_MODE];
      free_running_count <= pwdata[CS_FREE_RUN];
      active_low <= pwdata[CS_ACTIVE_LOW];
      input_select <= pwdata[CS_INPUT_SEL_LO +: 2];
      compare_irq_enable <= pwdata[CS_IRQ_ENABLE];
    end
  end

  // Divider setup is software's to hold steady while running.
  always_ff @(posedge clock) begin
    if (reset) begin
      clock_source_select <= SOURCE_RESET;
      filter_bypass <= 1'b0;
      divide_setting <= DIVIDE_RESET;
    end else if (wr_access && paddr == DIVIDER_CONFIG_OFS) begin
      clock_source_select <= pwdata[DC_SOURCE_LO +: 2];
      filter_bypass <= pwdata[DC_BYPASS];
      divide_setting <= pwdata[DC_DIVIDE_LO +: 4];
    end
  end

  // Compare is writable any time; a safe update relies on software.
  always_ff @(posedge clock) begin
    if (reset) begin
      compare_value <= COMPARE_RESET;
    end else if (wr_access && paddr == COMPARE_VALUE_OFS) begin
      compare_value <= pwdata[COUNT_WIDTH-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ---------------------------------------------------------------
  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      CONTROL_STATUS_OFS: begin
        next_prdata[CS_ENABLE] = timer_enable;
        next_prdata[CS_PULSE_MODE] = pulse_mode;
        next_prdata[CS_FREE_RUN] = free_running_count;
        next_prdata[CS_ACTIVE_LOW] = active_low;
        next_prdata[CS_INPUT_SEL_LO +: 2] = input_select;
        next_prdata[CS_IRQ_ENABLE] = compare_irq_enable;
        next_prdata[CS_FLAG] = compare_flag;
      end
      DIVIDER_CONFIG_OFS: begin
        next_prdata[DC_SOURCE_LO +: 2] = clock_source_select;
        next_prdata[DC_BYPASS] = filter_bypass;
        next_prdata[DC_DIVIDE_LO +: 4] = divide_setting;
      end
      COMPARE_VALUE_OFS: next_prdata[COUNT_WIDTH-1:0] = compare_value;
      COUNT_VALUE_OFS: next_prdata[COUNT_WIDTH-1:0] = count_snapshot;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // Data and error are registered so they stand through the access phase.
  always_ff @(posedge clock) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= !mapped;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_flag_off;
    !timer_enable |=> !compare_flag && !hw_trigger;
  endproperty
  a_flag_off: assert property (p_flag_off) else $error("flag alive while disabled");

  property p_count_clear;
    !timer_enable |=> count == 16'h0000;
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("count not cleared");

  property p_match_sets;
    compare_event |=> compare_flag && hw_trigger && (compare_irq == compare_irq_enable);
  endproperty
  a_match_sets: assert property (p_match_sets) else $error("compare did not fire");

  property p_match_reset;
    compare_event && !free_running_count && timer_enable ##1 timer_enable |-> count == 16'h0000;
  endproperty
  a_match_reset: assert property (p_match_reset) else $error("count not reset");

  property p_wrap;
    count_tick && !match && count == 16'hFFFF ##1 timer_enable |-> count == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("overflow did not wrap");

  property p_zero_hold;
    hw_trigger && compare_value == 16'h0000 && !free_running_count ##1 timer_enable
      |-> hw_trigger;
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("zero trigger dropped");

  property p_trig_drop;
    count_tick && !match && (compare_value != 16'h0000 || free_running_count) |=> !hw_trigger;
  endproperty
  a_trig_drop: assert property (p_trig_drop) else $error("trigger did not drop");

  property p_snapshot;
    wr_count |=> count_snapshot == $past(count);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("snapshot wrong");

  property p_debug_stop;
    debug_halt && !pulse_mode && timer_enable ##1 timer_enable |-> $stable(count);
  endproperty
  a_debug_stop: assert property (p_debug_stop) else $error("count moved in debug");

  property p_w0_keeps;
    compare_flag && timer_enable && wr_control && !pwdata[CS_FLAG] && pwdata[CS_ENABLE]
      |=> compare_flag;
  endproperty
  a_w0_keeps: assert property (p_w0_keeps) else $error("flag cleared by zero");

  property p_reserved;
    psel && penable && !pwrite |-> prdata[31:16] == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  c_compare: cover property (compare_event ##1 compare_irq);
  c_filter: cover property (pulse_mode && !filter_bypass && filter_tick);
  c_wrap: cover property (count_tick && count == 16'hFFFF);
  c_slverr: cover property (psel && penable && pslverr);

endmodule // lpt_timer

// ===== sim/test_lpt_timer.sv
`timescale 1ns/1ps
module test_lpt_timer
  import lpt_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and design instance
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] clock_source = 4'h0;
  logic [3:0] pulse_pin = 4'h0;
  logic debug_halt = 1'b0;
  logic compare_irq;
  logic hw_trigger;
  int n_fail = 0;
  int total_checks = 0;
  logic [31:0] rdv;
  logic errv;

  lpt_timer DUT (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clock_source(clock_source),
    .pulse_pin(pulse_pin), .debug_halt(debug_halt),
    .compare_irq(compare_irq), .hw_trigger(hw_trigger)
  );

  // The 125 MHz clock toggles every half period.
  always #4 clock = ~clock;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compares a seen value with the expected one and counts both outcomes.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      n_fail++;
      complete_run();
    end
    // One idle edge, so the next call never reassigns a strobe in this time step.
    @(posedge clock);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rdv, exp);
  endtask

  // A count read must be preceded by a write that takes the snapshot.
  task automatic rd_count(input logic [31:0] exp);
    wr(COUNT_VALUE_OFS, 32'h0000_0000);
    rd(COUNT_VALUE_OFS, exp);
  endtask

  // Pulses held four clocks high and low, beyond the three-clock minimum.
  task automatic pulses(input logic pin, input logic [3:0] m, input int n);
    repeat (n) begin
      if (pin) pulse_pin <= m; else clock_source <= m;
      repeat (4) @(posedge clock);
      if (pin) pulse_pin <= 4'h0; else clock_source <= 4'h0;
      repeat (4) @(posedge clock);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  // Configuration starts disabled and enables last, except the compare value moved while free running.
  initial begin
    logic [3:0] m;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(CONTROL_STATUS_OFS, 32'h0000_0000);
    rd(DIVIDER_CONFIG_OFS, 32'h0000_0000);
    rd(COMPARE_VALUE_OFS, 32'h0000_0000);
    rd_count(32'h0000_0000);
    wr(COMPARE_VALUE_OFS, 32'hffff_1234);
    rd(COMPARE_VALUE_OFS, 32'h0000_1234);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check({31'h0, errv}, 32'h0000_0001);
    check(rdv, 32'h0000_0000);
    // Every source toggles a different number of times; only one counts.
    for (int s = 0; s < 4; s++) begin
      wr(CONTROL_STATUS_OFS, 32'h0000_0000);
      wr(DIVIDER_CONFIG_OFS, 32'h0000_0004 | 32'(s));
      wr(CONTROL_STATUS_OFS, 32'h0000_0001);
      for (int j = 0; j < 6; j++) begin
        for (int i = 0; i < 4; i++) m[i] = (j < i + 2);
        pulses(1'b0, m, 1);
      end
      rd_count(32'(s + 2));
    end
    // Divide setting one: an increment every four source edges.
    wr(CONTROL_STATUS_OFS, 32'h0000_0000);
    wr(DIVIDER_CONFIG_OFS, 32'h0000_0008);
    wr(CONTROL_STATUS_OFS, 32'h0000_0001);
    pulses(1'b0, 4'h1, 10);
    rd_count(32'h0000_0002);
    // Compare three, no free running, interrupt enabled.
    wr(CONTROL_STATUS_OFS, 32'h0000_0000);
    wr(DIVIDER_CONFIG_OFS, 32'h0000_0004);
    wr(COMPARE_VALUE_OFS, 32'h0000_0003);
    wr(CONTROL_STATUS_OFS, 32'h0000_0041);
    pulses(1'b0, 4'h1, 4);
    check({31'h0, hw_trigger}, 32'h0000_0001);
    check({31'h0, compare_irq}, 32'h0000_0001);
    rd(CONTROL_STATUS_OFS, 32'h0000_00c1);
    rd_count(32'h0000_0000);
    pulses(1'b0, 4'h1, 1);
    check({31'h0, hw_trigger}, 32'h0000_0000);
    rd_count(32'h0000_0001);
    wr(CONTROL_STATUS_OFS, 32'h0000_0041);
    rd(CONTROL_STATUS_OFS, 32'h0000_00c1);
    wr(CONTROL_STATUS_OFS, 32'h0000_00c1);
    rd(CONTROL_STATUS_OFS, 32'h0000_0041);
    check({31'h0, compare_irq}, 32'h0000_0000);
    wr(CONTROL_STATUS_OFS, 32'h0000_0000);
    rd_count(32'h0000_0000);
    // Free running: the count passes the compare value without clearing.
    wr(COMPARE_VALUE_OFS, 32'h0000_0001);
    wr(CONTROL_STATUS_OFS, 32'h0000_0005);
    pulses(1'b0, 4'h1, 3);
    rd(CONTROL_STATUS_OFS, 32'h0000_0085);
    rd_count(32'h0000_0003);
    check({31'h0, hw_trigger}, 32'h0000_0000);
    // Compare moved while the flag is set, then the flag cleared before the count reaches it.
    wr(COMPARE_VALUE_OFS, 32'h0000_0005);
    wr(CONTROL_STATUS_OFS, 32'h0000_0085);
    rd(CONTROL_STATUS_OFS, 32'h0000_0005);
    pulses(1'b0, 4'h1, 3);
    rd(CONTROL_STATUS_OFS, 32'h0000_0085);
    rd_count(32'h0000_0006);
    check({31'h0, hw_trigger}, 32'h0000_0001);
    // Compare zero: the trigger sticks until the timer is disabled.
    wr(CONTROL_STATUS_OFS, 32'h0000_0000);
    wr(COMPARE_VALUE_OFS, 32'h0000_0000);
    wr(CONTROL_STATUS_OFS, 32'h0000_0041);
    pulses(1'b0, 4'h1, 3);
    check({31'h0, hw_trigger}, 32'h0000_0001);
    wr(CONTROL_STATUS_OFS, 32'h0000_0000);
    repeat (2) @(posedge clock);
    check({31'h0, hw_trigger}, 32'h0000_0000);
    rd(CONTROL_STATUS_OFS, 32'h0000_0000);
    // Debug halt freezes time mode but not pulse mode.
    wr(COMPARE_VALUE_OFS, 32'h0000_ffff);
    debug_halt <= 1'b1;
    wr(CONTROL_STATUS_OFS, 32'h0000_0001);
    pulses(1'b0, 4'h1, 3);
    rd_count(32'h0000_0000);
    wr(CONTROL_STATUS_OFS, 32'h0000_0000);
    pulse_pin <= 4'h4;
    wr(CONTROL_STATUS_OFS, 32'h0000_0023);
    repeat (6) @(posedge clock);
    pulse_pin <= 4'h0;
    repeat (4) @(posedge clock);
    pulses(1'b1, 4'h4, 2);
    rd_count(32'h0000_0002);
    debug_halt <= 1'b0;
    // Active-low filtered pulses with a two-edge filter; a one-edge glitch is dropped.
    wr(CONTROL_STATUS_OFS, 32'h0000_0000);
    wr(DIVIDER_CONFIG_OFS, 32'h0000_0008);
    wr(CONTROL_STATUS_OFS, 32'h0000_000b);
    pulses(1'b0, 4'h1, 3);
    rd_count(32'h0000_0000);
    pulse_pin <= 4'h1;
    pulses(1'b0, 4'h1, 3);
    pulse_pin <= 4'h0;
    pulses(1'b0, 4'h1, 3);
    rd_count(32'h0000_0001);
    pulse_pin <= 4'h1;
    pulses(1'b0, 4'h1, 1);
    pulse_pin <= 4'h0;
    pulses(1'b0, 4'h1, 3);
    rd_count(32'h0000_0001);
    complete_run();
  end
endmodule // test_lpt_timer
